/* File: src/fhr_fault_history_reset.sv */
// fault latch, history logging, snapshot capture and reset arbitration
// assumes all inputs synchronous to clk; faultEvent is a one-cycle pulse
//
// Notes on behaviour
// - keep codes of ten latest faults
// - store running time with each code
// - snapshot operating quantities on fault
// - slot one newest, slot ten oldest
// - power-cycle-only fault ignores reset key
// - configured terminal clears fault on close-open, except power-cycle-only
// - reset key clears resettable displayed fault
// - comms reset or power loss clears
// - alarm stays until its source clears
`timescale 1ns/1ns
`default_nettype none
module fhr_fault_history_reset
    import fhr_pkg::*;
#(
    parameter int INPUTS = MFI_N
) (
    input wire logic clk,
    input wire logic reset_n,
    // fault source
    input wire logic faultEvent,
    input wire logic [CODE_W-1:0] faultCode,
    input wire logic faultResettable,
    // running time and live quantities
    input wire logic [TIME_W-1:0] runTime,
    input wire logic [SNAP_N*SNAP_W-1:0] liveQuantities,
    // reset sources
    input wire logic [INPUTS-1:0] mfiLevel,
    input wire logic [INPUTS-1:0] mfiIsReset,
    input wire logic resetKey,
    input wire logic commReset,
    input wire logic powerRestore,
    // alarm
    input wire logic alarmSource,
    // history read port
    input wire logic [3:0] histIndex,
    output logic [CODE_W-1:0] histCode,
    output logic [TIME_W-1:0] histTime,
    // status
    output logic faultActive,
    output logic [CODE_W-1:0] currentFault,
    output logic alarmActive,
    output logic [SNAP_N*SNAP_W-1:0] faultSnapshot,
    output logic faultCleared
);
    // ==========================================================
    // elaboration check
    initial begin
        if (INPUTS < 1 || INPUTS > 32) begin
            $error("input count must lie between 1 and 32");
        end
    end

    // ==========================================================
    // reset source detection
    fhr_state_t state; // fault latch state
    logic [INPUTS-1:0] mfiPrev; // previous terminal levels
    logic terminalRelease; // a reset terminal opened after closing
    logic keyPrev; // previous key level
    logic keyPress; // key rising edge
    logic clearReq; // any accepted clear this cycle

    // previous levels for edge detection
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mfiPrev <= '0;
            keyPrev <= 1'b0;
        end else begin
            mfiPrev <= mfiLevel;
            keyPrev <= resetKey;
        end
    end

    // falling edge means terminal opened after being closed
    assign terminalRelease = |(mfiPrev & ~mfiLevel & mfiIsReset);
    assign keyPress = resetKey & ~keyPrev;

    // the wait is the operator's duty; no timer here
    // key only for resettable, non power-cycle faults
    // comms reset and power restore always clear
    always_comb begin
        clearReq = 1'b0;
        if (state == FHR_FAULTED) begin
            if (powerRestore || commReset) begin
                clearReq = 1'b1;
            end else if (currentFault == CODE_POWER_CYCLE_ONLY) begin
                clearReq = 1'b0;
            end else if (terminalRelease) begin
                clearReq = 1'b1;
            end else if (keyPress && faultResettable) begin
                clearReq = 1'b1;
            end
        end
    end

    // ==========================================================
    // fault latch; a new fault wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state <= FHR_IDLE;
            currentFault <= CODE_NONE;
        end else begin
            case (state)
                FHR_IDLE: begin
                    if (faultEvent) begin
                        state <= FHR_FAULTED;
                        currentFault <= faultCode;
                    end
                end
                FHR_FAULTED: begin
                    if (faultEvent) begin
                        currentFault <= faultCode;
                    end else if (clearReq) begin
                        state <= FHR_IDLE;
                        currentFault <= CODE_NONE;
                    end
                end
                default: begin
                    state <= FHR_IDLE;
                end
            endcase
        end
    end

    // status outputs, straight from flops
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            faultActive <= 1'b0;
            faultCleared <= 1'b0;
        end else begin
            faultActive <= (state == FHR_FAULTED && !(clearReq && !faultEvent)) || faultEvent;
            faultCleared <= (state == FHR_FAULTED) && clearReq && !faultEvent;
        end
    end

    // alarm follows its source; key has no effect
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            alarmActive <= 1'b0;
        end else begin
            alarmActive <= alarmSource;
        end
    end

    // ==========================================================
    // snapshot taken on every fault
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            faultSnapshot <= '0;
        end else if (faultEvent) begin
            faultSnapshot <= liveQuantities;
        end
    end

    // ==========================================================
    // history store; index 0 is slot one
    fhr_history_mem #(
        .DEPTH(HIST_DEPTH)
    ) uHistory (
        .clk(clk),
        .reset_n(reset_n),
        .push(faultEvent),
        .pushCode(faultCode),
        .pushTime(runTime),
        .readIndex(histIndex),
        .readCode(histCode),
        .readTime(histTime)
    );

    // ==========================================================
    // assertions
    property p_key_power_only;
        @(posedge clk) disable iff (!reset_n)
        (state == FHR_FAULTED && currentFault == CODE_POWER_CYCLE_ONLY && keyPress
         && !commReset && !powerRestore && !terminalRelease) |=> faultActive;
    endproperty
    a_key_power_only: assert property (p_key_power_only) else $error("key cleared power fault");

    property p_terminal_clear;
        @(posedge clk) disable iff (!reset_n)
        (state == FHR_FAULTED && terminalRelease && !faultEvent
         && currentFault != CODE_POWER_CYCLE_ONLY) |=> !faultActive && state == FHR_IDLE;
    endproperty
    a_terminal_clear: assert property (p_terminal_clear) else $error("terminal clear failed");

    property p_key_clear;
        @(posedge clk) disable iff (!reset_n)
        (state == FHR_FAULTED && keyPress && faultResettable && !faultEvent
         && currentFault != CODE_POWER_CYCLE_ONLY) |=> faultCleared;
    endproperty
    a_key_clear: assert property (p_key_clear) else $error("key clear failed");

    property p_comm_clear;
        @(posedge clk) disable iff (!reset_n)
        (state == FHR_FAULTED && (commReset || powerRestore) && !faultEvent)
        |=> faultCleared && state == FHR_IDLE;
    endproperty
    a_comm_clear: assert property (p_comm_clear) else $error("comm clear failed");

    property p_alarm_hold;
        @(posedge clk) disable iff (!reset_n)
        alarmSource |=> alarmActive;
    endproperty
    a_alarm_hold: assert property (p_alarm_hold) else $error("alarm dropped early");

    property p_snapshot;
        @(posedge clk) disable iff (!reset_n)
        faultEvent |=> faultSnapshot == $past(liveQuantities);
    endproperty
    a_snapshot: assert property (p_snapshot) else $error("snapshot missed");

    property p_newest;
        @(posedge clk) disable iff (!reset_n)
        (faultEvent && histIndex == 4'h0) ##1 !faultEvent && histIndex == 4'h0
        |=> histCode == $past(faultCode, 2) && histTime == $past(runTime, 2);
    endproperty
    a_newest: assert property (p_newest) else $error("newest slot wrong");

    property p_shift;
        @(posedge clk) disable iff (!reset_n)
        // registered read: slot two shows the first of two back-to-back faults
        // from the read taken one edge after the second push
        (faultEvent ##1 faultEvent ##1 histIndex == 4'h1)
        |=> histCode == $past(faultCode, 3);
    endproperty
    a_shift: assert property (p_shift) else $error("history did not shift");

    c_fault: cover property (@(posedge clk) disable iff (!reset_n) faultEvent ##1 faultActive);
    c_key: cover property (@(posedge clk) disable iff (!reset_n) faultCleared && keyPrev);
    c_term: cover property (@(posedge clk) disable iff (!reset_n)
        state == FHR_FAULTED && terminalRelease);
endmodule
`default_nettype wire

/* File: src/fhr_pkg.sv */
// package for the fault history and reset block: widths, counts and encodings
// assumes one 100 MHz clock and synchronous active-low reset in every user
package fhr_pkg;
    // ==========================================================
    // history geometry
    localparam int HIST_DEPTH = 10;
    localparam int CODE_W = 8;
    localparam int TIME_W = 32;
    // ==========================================================
    // snapshot geometry: ten quantities of sixteen bits each
    localparam int SNAP_N = 10;
    localparam int SNAP_W = 16;
    // ==========================================================
    // fault code values; only power-cycle-only has special clearing behaviour
    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_POWER_CYCLE_ONLY = 8'h0E;
    localparam logic [7:0] CODE_LINE_SWAP = 8'h10;
    // number of multifunction inputs
    localparam int MFI_N = 12;
    // ==========================================================
    // fault latch states
    typedef enum logic [1:0] {
        FHR_IDLE,
        FHR_FAULTED
    } fhr_state_t;
endpackage

/* File: src/fhr_history_mem.sv */
// history store: ten code/time pairs, newest at index 0, shifted on push
// assumes push is a one-cycle pulse and reads are registered one cycle later
`timescale 1ns/1ns
`default_nettype none
module fhr_history_mem
    import fhr_pkg::*;
#(
    parameter int DEPTH = HIST_DEPTH
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic push,
    input wire logic [CODE_W-1:0] pushCode,
    input wire logic [TIME_W-1:0] pushTime,
    input wire logic [3:0] readIndex,
    output logic [CODE_W-1:0] readCode,
    output logic [TIME_W-1:0] readTime
);
    // ==========================================================
    // storage
    initial begin
        if (DEPTH < 1 || DEPTH > 16) begin
            $error("history depth must lie between 1 and 16");
        end
    end
    logic [CODE_W-1:0] codeMem [DEPTH]; // fault codes, 0 = newest
    logic [TIME_W-1:0] timeMem [DEPTH]; // running time paired with each code

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : gSlot
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    codeMem[g] <= CODE_NONE;
                    timeMem[g] <= '0;
                end else if (push) begin
                    // oldest slot simply falls off the end
                    codeMem[g] <= (g == 0) ? pushCode : codeMem[(g == 0) ? 0 : g - 1];
                    timeMem[g] <= (g == 0) ? pushTime : timeMem[(g == 0) ? 0 : g - 1];
                end
            end
        end
    endgenerate

    // registered read; out-of-range index reads as empty
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            readCode <= CODE_NONE;
            readTime <= '0;
        end else if (32'(readIndex) < DEPTH) begin
            readCode <= codeMem[readIndex];
            readTime <= timeMem[readIndex];
        end else begin
            readCode <= CODE_NONE;
            readTime <= '0;
        end
    end
endmodule
`default_nettype wire

/* File: verification/fhr_operator_model.sv */
// operator side: keypad reset key, reset terminals, comms master, power
// assumes one bench process calls the tasks; lines change at falling edges
`timescale 1ns/1ns
`default_nettype none
module fhr_operator_model (
    input wire logic clk,
    output logic resetKey,
    output logic [11:0] mfiLevel,
    output logic commReset,
    output logic powerRestore
);
    // ==========================================================
    // idle: key up, terminals open to common, no commands
    initial begin
        resetKey = 1'b0;
        mfiLevel = 12'h000;
        commReset = 1'b0;
        powerRestore = 1'b0;
    end
    // key press held one cycle; the caller may check once it returns
    task automatic press();
        @(negedge clk) resetKey = 1'b1;
        @(negedge clk) resetKey = 1'b0;
    endtask
    // terminal closes to common, then opens; the open edge acts
    task automatic term(input int k);
        @(negedge clk) mfiLevel[k] = 1'b1;
        @(negedge clk) mfiLevel[k] = 1'b0;
        @(negedge clk);
    endtask
    // operator hold-off before resetting a protection trip
    // the five-minute wait is scaled to a few cycles to keep the run short
    task automatic hold_off(input int n);
        repeat (n) @(negedge clk);
    endtask
    // comms reset command, one cycle
    task automatic comm();
        @(negedge clk) commReset = 1'b1;
        @(negedge clk) commReset = 1'b0;
    endtask
    // power removed and restored
    task automatic power();
        @(negedge clk) powerRestore = 1'b1;
        @(negedge clk) powerRestore = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: verification/test_fhr_fault_history_reset.sv */
// bench: random faults against a queue model of the history, all clear paths
// assumes outputs settle one cycle after the edge that takes an input
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module test_fhr_fault_history_reset;
    import fhr_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, faultEvent = 1'b0, faultResettable = 1'b0;
    logic alarmSource = 1'b0, resetKey, commReset, powerRestore;
    logic [CODE_W-1:0] faultCode = 8'h00, histCode, currentFault;
    logic [TIME_W-1:0] runTime = 32'h0, histTime;
    logic [SNAP_N*SNAP_W-1:0] live = '0, faultSnapshot;
    logic [11:0] mfiLevel, mfiIsReset = 12'h000;
    logic [3:0] histIndex = 4'h0;
    logic faultActive, alarmActive, faultCleared;
    int n_errors = 0, checks_done = 0, seed = 98940, r;
    logic [39:0] histQ[$]; // model history, newest first
    logic [7:0] expCode;
    always #5 clk = ~clk;
    fhr_fault_history_reset i_dut (.clk(clk), .reset_n(reset_n), .faultEvent(faultEvent),
        .faultCode(faultCode), .faultResettable(faultResettable), .runTime(runTime),
        .liveQuantities(live), .mfiLevel(mfiLevel), .mfiIsReset(mfiIsReset),
        .resetKey(resetKey), .commReset(commReset), .powerRestore(powerRestore),
        .alarmSource(alarmSource), .histIndex(histIndex), .histCode(histCode),
        .histTime(histTime), .faultActive(faultActive), .currentFault(currentFault),
        .alarmActive(alarmActive), .faultSnapshot(faultSnapshot), .faultCleared(faultCleared));
    fhr_operator_model i_op (.clk(clk), .resetKey(resetKey), .mfiLevel(mfiLevel),
        .commReset(commReset), .powerRestore(powerRestore));
    // ==========================================================
    // one fault pulse with random time and quantities; model logs it
    task automatic fault(input logic [7:0] c, input logic res);
        @(negedge clk) faultEvent = 1'b1;
        faultCode = c;
        faultResettable = res;
        runTime = $random(seed);
        live = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
        @(negedge clk) faultEvent = 1'b0;
        histQ.push_front({c, runTime});
        if (histQ.size() > HIST_DEPTH) histQ.pop_back();
        expCode = c;
        `CHK(faultActive, 1'b1)
        `CHK(currentFault, c)
        `CHK(faultSnapshot, live)
    endtask
    // after a clear attempt: pulse and latch agree with the expectation
    task automatic cleared(input logic c);
        `CHK(faultCleared, c)
        `CHK(faultActive, ~c)
        `CHK(currentFault, c ? 8'h00 : expCode)
    endtask
    // two faults on consecutive edges; slot two must hold the first of them
    task automatic burst(input logic [7:0] c);
        @(negedge clk) faultEvent = 1'b1;
        faultCode = c;
        runTime = $random(seed);
        histQ.push_front({c, runTime});
        @(negedge clk) faultCode = c + 8'h01;
        runTime = $random(seed);
        histQ.push_front({faultCode, runTime});
        histIndex = 4'h1;
        @(negedge clk) faultEvent = 1'b0;
        while (histQ.size() > HIST_DEPTH) void'(histQ.pop_back());
        expCode = c + 8'h01;
        `CHK(currentFault, expCode)
        @(negedge clk);
        `CHK({histCode, histTime}, histQ[1])
    endtask
    // read every slot plus one past the end; empty slots read zero
    task automatic hist();
        for (int i = 0; i <= HIST_DEPTH; i++) begin
            @(negedge clk) histIndex = i[3:0];
            @(negedge clk);
            `CHK({histCode, histTime}, i < histQ.size() ? histQ[i] : 40'h0)
        end
    endtask
    task automatic stop_test();
        $display("errors=%0d checks=%0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        #50000;
        n_errors++;
        stop_test();
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        hist();
        // slot one watched while faults arrive, so the newest-slot check engages
        histIndex = 4'h0;
        // twelve faults overflow the ten slots; oldest two must drop
        for (int i = 0; i < 12; i++) begin
            r = $random(seed);
            fault(r[7:0] | 8'h01, 1'b1);
        end
        burst(8'h41);
        hist();
        i_op.hold_off(8);
        i_op.press();
        cleared(1'b1);
        fault(8'h21, 1'b0);
        i_op.press();
        cleared(1'b0);
        i_op.comm();
        cleared(1'b1);
        // power-cycle-only fault: key and terminal refused, power clears
        mfiIsReset = 12'hFFF;
        fault(CODE_POWER_CYCLE_ONLY, 1'b1);
        i_op.press();
        cleared(1'b0);
        i_op.term(3);
        cleared(1'b0);
        i_op.power();
        cleared(1'b1);
        // each terminal in turn: unconfigured neighbour refused, own clears
        for (int k = 0; k < MFI_N; k++) begin
            mfiIsReset = 12'h001 << k;
            fault(CODE_LINE_SWAP + k[7:0], 1'b0);
            i_op.term((k + 1) % MFI_N);
            cleared(1'b0);
            i_op.term(k);
            cleared(1'b1);
        end
        hist();
        // alarm ignores the key until its source goes away
        @(negedge clk) alarmSource = 1'b1;
        @(negedge clk);
        `CHK(alarmActive, 1'b1)
        i_op.press();
        `CHK(alarmActive, 1'b1)
        alarmSource = 1'b0;
        @(negedge clk);
        `CHK(alarmActive, 1'b0)
        stop_test();
    end
endmodule
`default_nettype wire
